//--- src/pltp_pkg.sv
// Shared constants and types for the lane transmit path
package pltp_pkg;
	localparam int LANES = 4;
	localparam int CHAR_W = 8;
	localparam int CODE_W = 10;
	localparam logic [7:0] COMMA_BYTE = 8'hbc;
	localparam logic [7:0] PAD_BYTE = 8'hf7;
	localparam logic [7:0] SKIP_BYTE = 8'h1c;
	localparam logic [4:0] HALT_LEN = 5'h10;
	localparam logic [15:0] LFSR_SEED = 16'hffff;
	localparam logic [7:0] LANE_SCRAMBLE_CONTROL_ADDR = 8'h05;
	localparam logic [7:0] QUAD_TX_SYNC_CONTROL_ADDR = 8'h30;
	localparam int SCR_DIS_BIT = 1;
	localparam int TX_SYNC_BIT = 5;
	localparam logic [7:0] REG_RESET = 8'h00;
	localparam int CLK_NS = 100;
	localparam int IDLE_MAX_NS = 120;
	localparam int IDLE_CYC = (IDLE_MAX_NS / CLK_NS < 1) ? 1 :
		IDLE_MAX_NS / CLK_NS;
	localparam int DETECT_NS = 1000;
	localparam int DETECT_CYC = (DETECT_NS + CLK_NS - 1) / CLK_NS;
	localparam int WAIT_IDLE_NS = 5000000;
	localparam int WAIT_IDLE_CYC = WAIT_IDLE_NS / CLK_NS;
	typedef enum logic [1:0] {
		PLTP_DET_IDLE = 2'b00,
		PLTP_DET_IDLE_WAIT = 2'b01,
		PLTP_DET_TEST = 2'b11,
		PLTP_DET_DONE = 2'b10
	} pltp_det_t;
endpackage

//--- src/pltp_if.sv
// Interface joining the fabric end and the transmit path end
`timescale 1ns/1ps
interface pltp_if #(parameter int LANES = 4, parameter int W = 8);
	logic [LANES-1:0][W-1:0] txd;
	logic [LANES-1:0][W/8-1:0] tx_k;
	logic [LANES-1:0][W/8-1:0] force_disp;
	logic [LANES-1:0][W/8-1:0] disp_sel;
	logic [LANES-1:0] scram_en;
	logic [LANES-1:0] elec_idle;
	logic [LANES-1:0] det_test;
	logic [LANES-1:0] det_result;
	logic [LANES-1:0] det_done;
	logic reg_wr;
	logic reg_rd;
	logic [7:0] reg_addr;
	logic [7:0] reg_wdata;
	logic [7:0] reg_rdata;
	modport dev (input txd, tx_k, force_disp, disp_sel, scram_en, elec_idle,
		det_test, reg_wr, reg_rd, reg_addr, reg_wdata,
		output det_result, det_done, reg_rdata);
	modport fab (output txd, tx_k, force_disp, disp_sel, scram_en, elec_idle,
		det_test, reg_wr, reg_rd, reg_addr, reg_wdata,
		input det_result, det_done, reg_rdata);
endinterface

//--- src/pltp_fabric.sv
// Fabric end: drives lane data and runs receiver detection with timing
`timescale 1ns/1ps
module pltp_fabric #(
	parameter int LANES = 4,
	parameter int W = 8,
	parameter int WAIT_CYC = pltp_pkg::WAIT_IDLE_CYC
) (
	// Clock and reset
	input wire logic clock,
	input wire logic rstn,
	// User side data
	input wire logic [LANES-1:0][W-1:0] u_data,
	input wire logic [LANES-1:0][W/8-1:0] u_k,
	input wire logic [LANES-1:0][W/8-1:0] u_force,
	input wire logic [LANES-1:0][W/8-1:0] u_sel,
	input wire logic [LANES-1:0] u_scram_en,
	input wire logic [LANES-1:0] u_idle,
	// User side detection
	input wire logic [LANES-1:0] u_det_start,
	output logic [LANES-1:0] u_det_busy,
	output logic [LANES-1:0] u_det_found,
	// User side registers
	input wire logic u_wr,
	input wire logic u_rd,
	input wire logic [7:0] u_addr,
	input wire logic [7:0] u_wdata,
	output logic [7:0] u_rdata,
	// Link
	pltp_if.fab link
);
	// ----------------------------------------
	// Data registered toward the device
	// ----------------------------------------
	// Data and flags follow the lane clock
	always_ff @(posedge clock) begin
		if (!rstn) begin
			link.txd <= '0;
			link.tx_k <= '0;
			link.force_disp <= '0;
			link.disp_sel <= '0;
			link.scram_en <= '0;
		end else begin
			link.txd <= u_data; // RL1 RL2
			link.tx_k <= u_k; // RL3
			link.force_disp <= u_force;
			link.disp_sel <= u_sel;
			link.scram_en <= u_scram_en;
		end
	end
	// Register pass-through
	always_ff @(posedge clock) begin
		if (!rstn) begin
			link.reg_wr <= 1'b0;
			link.reg_rd <= 1'b0;
			link.reg_addr <= '0;
			link.reg_wdata <= '0;
		end else begin
			link.reg_wr <= u_wr;
			link.reg_rd <= u_rd;
			link.reg_addr <= u_addr;
			link.reg_wdata <= u_wdata;
		end
	end
	assign u_rdata = link.reg_rdata;
	// ----------------------------------------
	// Detection sequencer per lane
	// ----------------------------------------
	pltp_pkg::pltp_det_t st_reg [LANES];
	logic [31:0] cnt_reg [LANES];
	logic [LANES-1:0] idle_reg;
	logic [LANES-1:0] test_reg;
	logic [LANES-1:0] found_reg;
	assign link.elec_idle = idle_reg;
	assign link.det_test = test_reg;
	assign u_det_found = found_reg;
	for (genvar i = 0; i < LANES; i++) begin : g_det
		assign u_det_busy[i] = (st_reg[i] != pltp_pkg::PLTP_DET_IDLE);
		// Idle hold, test pulse, then wait for done
		always_ff @(posedge clock) begin
			if (!rstn) begin
				st_reg[i] <= pltp_pkg::PLTP_DET_IDLE;
				cnt_reg[i] <= '0;
				idle_reg[i] <= 1'b0;
				test_reg[i] <= 1'b0;
				found_reg[i] <= 1'b0;
			end else begin
				case (st_reg[i])
				pltp_pkg::PLTP_DET_IDLE: begin
					idle_reg[i] <= u_idle[i];
					if (u_det_start[i]) begin
						idle_reg[i] <= 1'b1;
						cnt_reg[i] <= '0;
						st_reg[i] <= pltp_pkg::PLTP_DET_IDLE_WAIT;
					end
				end
				pltp_pkg::PLTP_DET_IDLE_WAIT: begin
					cnt_reg[i] <= cnt_reg[i] + 32'h1;
					if (cnt_reg[i] >= 32'(WAIT_CYC)) begin // RL20
						test_reg[i] <= 1'b1; // RL17
						cnt_reg[i] <= '0;
						st_reg[i] <= pltp_pkg::PLTP_DET_TEST;
					end
				end
				pltp_pkg::PLTP_DET_TEST: begin
					cnt_reg[i] <= cnt_reg[i] + 32'h1;
					if (cnt_reg[i] >= 32'(pltp_pkg::DETECT_CYC - 1)) begin
						test_reg[i] <= 1'b0; // RL21
						st_reg[i] <= pltp_pkg::PLTP_DET_DONE;
					end
				end
				pltp_pkg::PLTP_DET_DONE: begin
					if (link.det_done[i]) begin
						found_reg[i] <= link.det_result[i];
						st_reg[i] <= pltp_pkg::PLTP_DET_IDLE;
					end
				end
				default: st_reg[i] <= pltp_pkg::PLTP_DET_IDLE;
				endcase
			end
		end
	end
endmodule

//--- src/pltp_lanes.sv
// Device end: scrambler, 8b10b encoder, serializer, idle and detection
//
// Summary of operation
// [RL1] Four lanes take independent eight-bit data
// [RL2] Wide option: sixteen bits, two flag bits
// [RL3] High flag marks byte as control character
// [RL4] Force input selects given disparity, one positive
// [RL5] Scrambler follows enable one cycle later
// [RL6] Control and training bytes never scrambled
// [RL7] Comma halts scrambling, starts byte counter
// [RL8] Scrambling resumes when counter reaches sixteen
// [RL9] Non-pad control ends halt early
// [RL10] Comma reloads scrambler seed
// [RL11] Eight shifts per character, skip excepted
// [RL12] Disable register bit overrides enable port
// [RL13] Bytes become 8b10b codes, disparity tracked
// [RL14] Codes serialized onto differential pair
// [RL15] Sync bit aligns all four lanes
// [RL16] Idle input holds output in idle
// [RL17] Test input starts detection, clears result
// [RL18] Result high means receiver found
// [RL19] Done rises after expected test time
// [RL20] Fabric holds idle 5 ms before test
// [RL21] Fabric pulses test about one microsecond
// [RL22] Idle entered within 120 ns
`timescale 1ns/1ps
module pltp_lanes #(
	parameter int LANES = 4,
	parameter int W = 8
) (
	// Clock and reset
	input wire logic clock,
	input wire logic rstn,
	// Link to fabric
	pltp_if.dev link,
	// Serial pads and far end sense
	output logic [LANES-1:0] pad_p,
	output logic [LANES-1:0] pad_n,
	input wire logic [LANES-1:0] far_rx_sense
);
	localparam int NB = W / 8;
	localparam int SW = NB * pltp_pkg::CODE_W;

	// ----------------------------------------
	// Helper functions
	// ----------------------------------------
	// Eight serial shifts of the 16-bit LFSR, returns next state
	function automatic logic [15:0] lfsr_adv(input logic [15:0] s);
		logic [15:0] v;
		v = s;
		for (int b = 0; b < 8; b++) begin
			v = {v[14:0], 1'b0} ^ (v[15] ? 16'h0039 : 16'h0000);
		end
		return v;
	endfunction
	// Keystream byte taken from LFSR high bits
	function automatic logic [7:0] lfsr_key(input logic [15:0] s);
		logic [7:0] k;
		logic [15:0] v;
		v = s;
		k = 8'h00;
		for (int b = 0; b < 8; b++) begin
			k[b] = v[15];
			v = {v[14:0], 1'b0} ^ (v[15] ? 16'h0039 : 16'h0000);
		end
		return k;
	endfunction
	// 5b6b code, RD- form; flip when balance nonzero and RD+
	function automatic logic [5:0] enc6(input logic [4:0] x);
		logic [5:0] t [32];
		t = '{6'h27,6'h1d,6'h2d,6'h31,6'h35,6'h29,6'h19,6'h38,
			6'h39,6'h25,6'h15,6'h34,6'h0d,6'h2c,6'h1c,6'h17,
			6'h1b,6'h23,6'h13,6'h32,6'h0b,6'h2a,6'h1a,6'h3a,
			6'h33,6'h26,6'h16,6'h36,6'h0e,6'h2e,6'h1e,6'h2b};
		return t[x];
	endfunction
	// 3b4b code, RD- form
	function automatic logic [3:0] enc4(input logic [2:0] y, input logic k);
		logic [3:0] t [8];
		t = '{4'hb,4'h9,4'h5,4'hc,4'hd,4'ha,4'h6,4'he};
		return (k && y == 3'h7) ? 4'h7 : t[y];
	endfunction
	// Ones count of a sub-block
	function automatic logic [2:0] ones(input logic [5:0] v);
		return 3'(v[0]) + 3'(v[1]) + 3'(v[2]) + 3'(v[3]) + 3'(v[4]) + 3'(v[5]);
	endfunction

	// ----------------------------------------
	// Register file
	// ----------------------------------------
	logic [7:0] scr_ctl_reg;
	logic [7:0] sync_ctl_reg;
	logic [7:0] rdata_reg;
	// Register writes
	always_ff @(posedge clock) begin
		if (!rstn) begin
			scr_ctl_reg <= pltp_pkg::REG_RESET;
			sync_ctl_reg <= pltp_pkg::REG_RESET;
		end else if (link.reg_wr) begin
			if (link.reg_addr == pltp_pkg::LANE_SCRAMBLE_CONTROL_ADDR)
				scr_ctl_reg <= link.reg_wdata;
			else if (link.reg_addr == pltp_pkg::QUAD_TX_SYNC_CONTROL_ADDR)
				sync_ctl_reg <= link.reg_wdata;
		end
	end
	// Read data one cycle after strobe, unmapped reads zero
	always_ff @(posedge clock) begin
		if (!rstn)
			rdata_reg <= '0;
		else if (!link.reg_rd)
			rdata_reg <= '0;
		else if (link.reg_addr == pltp_pkg::LANE_SCRAMBLE_CONTROL_ADDR)
			rdata_reg <= scr_ctl_reg;
		else if (link.reg_addr == pltp_pkg::QUAD_TX_SYNC_CONTROL_ADDR)
			rdata_reg <= sync_ctl_reg;
		else
			rdata_reg <= '0;
	end
	assign link.reg_rdata = rdata_reg;
	wire scr_dis = scr_ctl_reg[pltp_pkg::SCR_DIS_BIT];
	wire tx_sync = sync_ctl_reg[pltp_pkg::TX_SYNC_BIT];

	// ----------------------------------------
	// Per-lane datapath
	// ----------------------------------------
	logic [LANES-1:0] ser_load;
	logic [3:0] phase_reg;
	// Shared word phase: sync bit aligns all lanes to one phase
	always_ff @(posedge clock) begin
		if (!rstn || !tx_sync)
			phase_reg <= '0; // RL15
		else
			phase_reg <= (phase_reg == 4'(SW - 1)) ? '0 : phase_reg + 4'h1;
	end

	for (genvar i = 0; i < LANES; i++) begin : g_lane
		logic en_reg;
		logic halt_reg;
		logic kill_reg;
		logic [4:0] bcnt_reg;
		logic [15:0] lfsr_reg;
		logic rd_reg;
		logic [SW-1:0] code_reg;
		logic [SW-1:0] shift_reg;
		logic [3:0] lphase_reg;
		logic idle_reg;
		logic [7:0] dcnt_reg;
		logic run_reg;
		logic res_reg;
		logic done_reg;
		logic [SW-1:0] code_next;
		logic rd_next;
		logic halt_next;
		logic kill_next;
		logic [4:0] bcnt_next;
		logic [15:0] lfsr_next;

		// Enable follows port one cycle later, register wins
		always_ff @(posedge clock) begin
			if (!rstn)
				en_reg <= 1'b0;
			else
				en_reg <= link.scram_en[i] && !scr_dis; // RL5 RL12
		end

		// Scramble and encode each byte lane in order
		always_comb begin
			logic [7:0] d;
			logic [7:0] sd;
			logic k;
			logic [5:0] a;
			logic [3:0] b;
			logic rd;
			d = '0;
			sd = '0;
			k = 1'b0;
			a = '0;
			b = '0;
			rd = rd_reg;
			halt_next = halt_reg;
			kill_next = kill_reg;
			bcnt_next = bcnt_reg;
			lfsr_next = lfsr_reg;
			code_next = '0;
			for (int j = 0; j < NB; j++) begin
				d = link.txd[i][j*8 +: 8];
				k = link.tx_k[i][j]; // RL3 RL2
				sd = d;
				if (k && d == pltp_pkg::COMMA_BYTE) begin
					halt_next = 1'b1; // RL7
					kill_next = 1'b0;
					bcnt_next = 5'h1;
				end else if (halt_next) begin
					if (k && d != pltp_pkg::PAD_BYTE)
						kill_next = 1'b1; // RL9
					else if (kill_next && !k) begin
						halt_next = 1'b0; // RL9
						kill_next = 1'b0;
					end
					if (halt_next && !kill_next) begin
						bcnt_next = bcnt_next + 5'h1;
						if (bcnt_next == pltp_pkg::HALT_LEN)
							halt_next = 1'b0; // RL8
					end
				end
				if (en_reg && !k && !halt_next && !kill_next)
					sd = d ^ lfsr_key(lfsr_next); // RL6
				if (k && d == pltp_pkg::COMMA_BYTE)
					lfsr_next = pltp_pkg::LFSR_SEED; // RL10
				else if (!(k && d == pltp_pkg::SKIP_BYTE))
					lfsr_next = lfsr_adv(lfsr_next); // RL11
				a = enc6(sd[4:0]);
				if (k && sd[4:0] == 5'h1c)
					a = 6'h0f;
				b = enc4(sd[7:5], k);
				if (link.force_disp[i][j])
					rd = link.disp_sel[i][j]; // RL4
				if (rd && ones(a) != 3'h3)
					a = ~a;
				if (rd ^ (ones(a) != 3'h3))
					b = ~b;
				if (ones({2'b00, b}) != 3'h2 || ones(a) != 3'h3)
					rd = ~rd; // RL13
				code_next[j*10 +: 10] = {a, b};
			end
			rd_next = rd;
		end

		// Encoder and scrambler state, NB characters per serial word
		always_ff @(posedge clock) begin
			if (!rstn) begin
				rd_reg <= 1'b0;
				halt_reg <= 1'b0;
				kill_reg <= 1'b0;
				bcnt_reg <= '0;
				lfsr_reg <= pltp_pkg::LFSR_SEED;
				code_reg <= '0;
			end else if (ser_load[i]) begin
				rd_reg <= rd_next;
				halt_reg <= halt_next;
				kill_reg <= kill_next;
				bcnt_reg <= bcnt_next;
				lfsr_reg <= lfsr_next;
				code_reg <= code_next;
			end
		end

		// Serializer, one bit per clock, load at word phase
		assign ser_load[i] = (lphase_reg == 4'(SW - 1));
		always_ff @(posedge clock) begin
			if (!rstn) begin
				shift_reg <= '0;
				lphase_reg <= '0;
			end else begin
				lphase_reg <= tx_sync ? phase_reg :
					(ser_load[i] ? '0 : lphase_reg + 4'h1);
				shift_reg <= ser_load[i] ? code_reg : shift_reg << 1; // RL14
			end
		end

		// Idle, entered within one cycle of the input
		always_ff @(posedge clock) begin
			if (!rstn)
				idle_reg <= 1'b1;
			else
				idle_reg <= link.elec_idle[i]; // RL16 RL22
		end
		assign pad_p[i] = !idle_reg && shift_reg[SW-1];
		assign pad_n[i] = !idle_reg && !shift_reg[SW-1];

		// Receiver detection: test clears, done the cycle after test drops
		always_ff @(posedge clock) begin
			if (!rstn) begin
				run_reg <= 1'b0;
				res_reg <= 1'b0;
				done_reg <= 1'b0;
				dcnt_reg <= '0;
			end else if (link.det_test[i]) begin
				done_reg <= 1'b0; // RL17
				res_reg <= 1'b0;
				run_reg <= 1'b1;
				if (dcnt_reg != 8'(pltp_pkg::DETECT_CYC))
					dcnt_reg <= dcnt_reg + 8'h1;
			end else if (run_reg) begin
				run_reg <= 1'b0;
				done_reg <= 1'b1; // RL19
				res_reg <= far_rx_sense[i] && idle_reg; // RL18
				dcnt_reg <= '0;
			end
		end
		assign link.det_result[i] = res_reg;
		assign link.det_done[i] = done_reg;
	end
endmodule

//--- tb/pltp_monitor.sv
// Checker on the link between the fabric end and the lane end
`timescale 1ns/1ps
module pltp_monitor #(
	parameter int LANES = 4
) (
	// Clock and reset
	input wire logic clock,
	input wire logic rstn,
	// Detection
	input wire logic [LANES-1:0] det_test,
	input wire logic [LANES-1:0] elec_idle,
	input wire logic [LANES-1:0] det_done,
	input wire logic [LANES-1:0] det_result,
	// Registers
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [7:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic [7:0] reg_rdata
);
	default clocking @(posedge clock);
	endclocking
	default disable iff (!rstn);
	logic scr_reg;
	logic sync_reg;
	// Shadow of the two control bits
	always_ff @(posedge clock) begin
		if (!rstn) begin
			scr_reg <= 1'b0;
			sync_reg <= 1'b0;
		end else if (reg_wr) begin
			if (reg_addr == pltp_pkg::LANE_SCRAMBLE_CONTROL_ADDR)
				scr_reg <= reg_wdata[pltp_pkg::SCR_DIS_BIT];
			if (reg_addr == pltp_pkg::QUAD_TX_SYNC_CONTROL_ADDR)
				sync_reg <= reg_wdata[pltp_pkg::TX_SYNC_BIT];
		end
	end
	// Register read path
	a_scr_readback: assert property (reg_rd &&
		reg_addr == pltp_pkg::LANE_SCRAMBLE_CONTROL_ADDR |=>
		reg_rdata[pltp_pkg::SCR_DIS_BIT] == scr_reg)
		else $error("disable bit readback wrong");
	a_sync_readback: assert property (reg_rd &&
		reg_addr == pltp_pkg::QUAD_TX_SYNC_CONTROL_ADDR |=>
		reg_rdata[pltp_pkg::TX_SYNC_BIT] == sync_reg)
		else $error("sync bit readback wrong");
	a_rdata_quiet: assert property (!reg_rd |=> reg_rdata == 8'h00)
		else $error("read data outside read cycle");
	// Detection handshake per lane
	for (genvar i = 0; i < LANES; i++) begin : g_ln
		a_done_after_fall: assert property ($fell(det_test[i]) |=>
			det_done[i])
			else $error("done missing after test end");
		a_test_clears: assert property (det_test[i] |=>
			!det_done[i] && !det_result[i])
			else $error("result not cleared by test");
		a_result_holds: assert property (det_done[i] && !det_test[i] |=>
			det_done[i] && $stable(det_result[i]))
			else $error("result moved while done");
		a_result_gated: assert property (det_result[i] |-> det_done[i])
			else $error("result without done");
		a_test_in_idle: assert property (det_test[i] |-> elec_idle[i])
			else $error("test outside idle");
		a_test_width: assert property ($rose(det_test[i]) |->
			det_test[i] [*8] ##[1:4] !det_test[i])
			else $error("test pulse width wrong");
	end
	// Main scenarios reached
	c_done: cover property ($rose(det_done[0]));
	c_found: cover property ($rose(det_result[0]));
	c_scr_rd: cover property (reg_rd && reg_addr == 8'h05);
endmodule

//--- tb/tb_pcie_lane_transmit_path.sv
// Testbench: fabric end and lane end joined back to back
`timescale 1ns/1ps
module tb_pcie_lane_transmit_path;
	localparam int L = 4;
	logic clock = 1'b0;
	logic rstn = 1'b0;
	logic [L-1:0][7:0] u_data = '0;
	logic [L-1:0][0:0] u_k = '0;
	logic [L-1:0][0:0] u_force = '0;
	logic [L-1:0][0:0] u_sel = '0;
	logic [L-1:0] u_scram_en = '0;
	logic [L-1:0] u_idle = '1;
	logic [L-1:0] u_det_start = '0;
	logic [L-1:0] u_det_busy;
	logic [L-1:0] u_det_found;
	logic u_wr = 1'b0;
	logic u_rd = 1'b0;
	logic [7:0] u_addr = 8'h00;
	logic [7:0] u_wdata = 8'h00;
	logic [7:0] u_rdata;
	logic [L-1:0] pad_p;
	logic [L-1:0] pad_n;
	logic [L-1:0] sense = '0;
	int n_errors = 0;
	int cmp_count = 0;
	int o1;
	int o0;
	logic per;
	// Clock
	initial forever #50 clock = ~clock;
	pltp_if #(.LANES(L), .W(8)) lk ();
	pltp_fabric #(.LANES(L), .W(8), .WAIT_CYC(20)) i_pltp_fabric (
		.clock(clock), .rstn(rstn), .u_data(u_data), .u_k(u_k),
		.u_force(u_force), .u_sel(u_sel), .u_scram_en(u_scram_en),
		.u_idle(u_idle), .u_det_start(u_det_start), .u_det_busy(u_det_busy),
		.u_det_found(u_det_found), .u_wr(u_wr), .u_rd(u_rd),
		.u_addr(u_addr), .u_wdata(u_wdata), .u_rdata(u_rdata), .link(lk));
	pltp_lanes #(.LANES(L), .W(8)) i_pltp_lanes (.clock(clock),
		.rstn(rstn), .link(lk), .pad_p(pad_p), .pad_n(pad_n),
		.far_rx_sense(sense));
	pltp_monitor #(.LANES(L)) i_pltp_monitor (.clock(clock), .rstn(rstn),
		.det_test(lk.det_test), .elec_idle(lk.elec_idle),
		.det_done(lk.det_done), .det_result(lk.det_result),
		.reg_wr(lk.reg_wr), .reg_rd(lk.reg_rd), .reg_addr(lk.reg_addr),
		.reg_wdata(lk.reg_wdata), .reg_rdata(lk.reg_rdata));
	// Compare and count
	task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
		cmp_count++;
		if (got !== exp) begin
			n_errors++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic stop_test;
		$display("errors=%0d compares=%0d", n_errors, cmp_count);
		if (n_errors == 0 && cmp_count > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	// Register access through the fabric
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		u_wr <= 1'b1;
		u_addr <= a;
		u_wdata <= d;
		@(posedge clock);
		u_wr <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, input logic [7:0] e);
		u_rd <= 1'b1;
		u_addr <= a;
		@(posedge clock);
		u_rd <= 1'b0;
		@(posedge clock);
		#1 cmp(u_rdata, e);
		@(posedge clock);
	endtask
	// Capture 40 serial bits of lane 0
	task automatic grab(output int ones, output logic p);
		logic [39:0] s;
		repeat (30) @(posedge clock);
		for (int j = 0; j < 40; j++) begin
			@(posedge clock);
			#1 s[j] = pad_p[0];
		end
		@(posedge clock);
		ones = $countones(s[19:0]);
		p = (s[19:0] == s[39:20]);
	endtask
	// One detection run with a given far end
	task automatic detect(input logic [L-1:0] fr);
		int k;
		@(posedge clock);
		sense <= fr;
		u_det_start <= '1;
		@(posedge clock);
		u_det_start <= '0;
		for (k = 0; k < 300 && lk.det_test[0] !== 1'b1; k++)
			@(posedge clock);
		repeat (2) @(posedge clock);
		#1 cmp({lk.det_done, lk.det_result}, 0);
		for (k = 0; k < 300 && u_det_busy !== '0; k++)
			@(posedge clock);
		repeat (3) @(posedge clock);
		#1 cmp(lk.det_done, 4'hf);
		cmp(lk.det_result, fr);
		cmp(u_det_found, fr);
	endtask
	// Watchdog
	initial begin
		#500000;
		n_errors++;
		stop_test();
	end
	// Main sequence
	initial begin
		repeat (12) @(posedge clock);
		rstn <= 1'b1;
		@(posedge clock);
		rd(8'h05, 8'h00);
		rd(8'h30, 8'h00);
		wr(8'h30, 8'h20);
		rd(8'h30, 8'h20);
		rd(8'h11, 8'h00);
		u_idle <= '0;
		u_data <= {L{pltp_pkg::COMMA_BYTE}};
		u_k <= '1;
		grab(o1, per);
		cmp(o1, 10);
		cmp(pad_p ^ pad_n, 4'hf);
		u_scram_en <= '1;
		grab(o1, per);
		cmp(o1, 10);
		u_force <= '1;
		u_sel <= '1;
		grab(o1, per);
		u_sel <= '0;
		grab(o0, per);
		cmp(o1 + o0, 20);
		cmp(o1 != 10, 1);
		u_force <= '0;
		u_k <= '0;
		u_data <= '0;
		// Let the comma halt count run out before looking
		repeat (200) @(posedge clock);
		grab(o1, per);
		cmp(per, 0);
		u_scram_en <= '0;
		grab(o1, per);
		cmp(per, 1);
		u_scram_en <= '1;
		wr(8'h05, 8'h02);
		grab(o1, per);
		cmp(per, 1);
		rd(8'h05, 8'h02);
		u_idle <= '1;
		repeat (2) @(posedge clock);
		#1 cmp({pad_p, pad_n}, 0);
		detect(4'h5);
		detect(4'ha);
		stop_test();
	end
endmodule
